/* design/uart_core.sv */
// Serial port top: AXI4-Lite registers, transmitter, receive buffer
`timescale 1ns/1ns
`default_nettype none
module uart_core (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address
    input wire logic awvalid,
    output logic awready,
    input wire logic [uart_pkg::AXI_ADDR_W-1:0] awaddr,
    // AXI4-Lite write data
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    // AXI4-Lite write response
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // AXI4-Lite read address
    input wire logic arvalid,
    output logic arready,
    input wire logic [uart_pkg::AXI_ADDR_W-1:0] araddr,
    // AXI4-Lite read data
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // Serial pins
    output logic serial_out_pin,
    output logic serial_out_oe,
    input wire logic serial_in_pin,
    output logic serial_in_owned,
    input wire logic external_transfer_clock,
    // Interrupt requests towards the CPU core
    input wire logic global_irq_enable,
    input wire logic tx_done_irq_ack,
    output logic buffer_empty_irq,
    output logic tx_done_irq
);
    import uart_pkg::*;

    rx_link_if link ();

    logic [7:0] ctrl_b;
    logic [7:0] ctrl_c;
    logic [11:0] baud_div;
    logic [11:0] baud_count;
    logic tick16;
    logic ext_clk_q;
    logic [8:0] tx_buf;
    logic tx_full;
    logic tx_done;
    logic tx_live;
    tx_state_t tx_state;
    logic [3:0] tx_phase;
    logic [3:0] tx_bits;
    logic [8:0] tx_shreg;
    logic tx_parity;
    logic tx_stops;
    logic tx_line;
    logic [ENTRY_W-1:0] fifo_mem [FIFO_DEPTH];
    logic wr_ptr;
    logic rd_ptr;
    logic [1:0] rx_count;
    logic overrun_pending;

    // Control fields
    wire [2:0] character_size = {ctrl_b[B_SIZE2], ctrl_c[C_SIZE_HI],
        ctrl_c[C_SIZE_LO]};
    wire [3:0] data_bits = (character_size == SIZE_NINE) ? NINE_BITS :
        MIN_BITS + {2'b00, character_size[1:0]};
    wire [8:0] data_mask = 9'h1ff >> (NINE_BITS - data_bits);
    wire transmitter_on = ctrl_b[B_TX_ON];
    wire receiver_on = ctrl_b[B_RX_ON];
    wire sync_mode = ctrl_c[C_SYNC];
    wire parity_enable_bit = ctrl_c[C_PAR_EN];
    wire parity_odd_select = ctrl_c[C_PAR_ODD];
    wire stop_bits_select = ctrl_c[C_STOP2];
    wire ext_rise = external_transfer_clock && !ext_clk_q;

    // Bus handshakes: address and data taken together, one at a time
    wire wr_go = awvalid && wvalid && !bvalid;
    wire rd_go = arvalid && !rvalid;
    wire [AXI_ADDR_W-1:0] wa = awaddr;
    wire [AXI_ADDR_W-1:0] ra = araddr;
    wire wr_data = wr_go && wa == OFS_DATA && wstrb[0];
    wire wr_csa = wr_go && wa == OFS_CSA && wstrb[0];
    wire wr_csb = wr_go && wa == OFS_CSB && wstrb[0];
    wire wr_csc = wr_go && wa == OFS_CSC && wstrb[0];
    wire wr_baud = wr_go && wa == OFS_BAUD;
    wire wr_hit = wa == OFS_DATA || wa == OFS_CSA || wa == OFS_CSB ||
        wa == OFS_CSC || wa == OFS_BAUD;
    wire rd_hit = ra == OFS_DATA || ra == OFS_CSA || ra == OFS_CSB ||
        ra == OFS_CSC || ra == OFS_BAUD;
    assign awready = wr_go;
    assign wready = wr_go;
    assign arready = !rvalid;

    // Receive buffer head and pop
    wire [ENTRY_W-1:0] head = fifo_mem[rd_ptr];
    wire rx_complete_flag = rx_count != 2'd0;
    wire pop = rd_go && ra == OFS_DATA && rx_complete_flag;
    wire rx_full = rx_count == 2'(FIFO_DEPTH);
    wire push = link.frame_valid && !rx_full;
    wire lost = link.frame_valid && rx_full;
    wire rx_ninth_bit = rx_complete_flag && head[11];
    wire frame_error_flag = rx_complete_flag && head[10];
    wire overrun_flag = rx_complete_flag && head[9];
    wire parity_error_flag = rx_complete_flag && head[8];

    // Transmitter status
    wire tx_buffer_empty = !tx_full;
    wire tx_tick = sync_mode ? ext_rise :
        (tick16 && tx_phase == PHASE_LAST);
    wire tx_last_stop = tx_state == TX_STOP && tx_tick &&
        tx_stops == stop_bits_select;
    wire tx_load = tx_full && tx_live &&
        ((tx_state == TX_IDLE && tx_tick) || tx_last_stop);
    wire tx_busy = tx_state != TX_IDLE;
    wire next_tx_live = transmitter_on ||
        (tx_live && (tx_busy || tx_full));
    wire [8:0] load_data = tx_buf & data_mask;

    // Status words as read back
    wire [7:0] csa_word = {rx_complete_flag, tx_done, tx_buffer_empty,
        frame_error_flag, overrun_flag, parity_error_flag, 2'b00};
    wire [7:0] csb_word = {1'b0, ctrl_b[6:2], rx_ninth_bit,
        ctrl_b[B_TX_NINTH]};
    wire [31:0] rd_word =
        (ra == OFS_DATA) ? {24'h0, head[7:0] & data_mask[7:0]} :
        (ra == OFS_CSA) ? {24'h0, csa_word} :
        (ra == OFS_CSB) ? {24'h0, csb_word} :
        (ra == OFS_CSC) ? {24'h0, ctrl_c} :
        (ra == OFS_BAUD) ? {20'h0, baud_div} : 32'h0;

    // Pins and interrupt requests
    assign serial_out_pin = tx_line;
    assign serial_out_oe = tx_live;
    assign serial_in_owned = receiver_on;
    assign buffer_empty_irq = ctrl_b[B_EMPTY_IE] && tx_buffer_empty &&
        global_irq_enable;
    assign tx_done_irq = ctrl_b[B_TXDONE_IE] && tx_done &&
        global_irq_enable;

    // Receive shifter hookup
    assign link.enable = receiver_on;
    assign link.sync_mode = sync_mode;
    assign link.tick16 = tick16;
    assign link.ext_rise = ext_rise;
    assign link.serial_in = serial_in_pin;
    assign link.parity_en = parity_enable_bit;
    assign link.parity_odd = parity_odd_select;
    assign link.data_bits = data_bits;

    rx_shifter u_rx (
        .aclk(aclk),
        .aresetn(aresetn),
        .link(link)
    );

    // Write response: one cycle after the write is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
        end else if (wr_go) begin
            bvalid <= 1'b1;
            bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    // Read data: one cycle after the address is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata <= '0;
            rresp <= RESP_OKAY;
        end else if (rd_go) begin
            rvalid <= 1'b1;
            rdata <= rd_word;
            rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end

    // Control registers; rx_ninth_bit position is read-only
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_b <= RESET_CSB;
            ctrl_c <= RESET_CSC;
            baud_div <= RESET_BAUD;
        end else begin
            if (wr_csb) begin
                ctrl_b <= wdata[7:0] & B_WRITE_MASK;
            end
            if (wr_csc) begin
                ctrl_c <= wdata[7:0];
            end
            if (wr_baud && wstrb[0]) begin
                baud_div[7:0] <= wdata[7:0];
            end
            if (wr_baud && wstrb[1]) begin
                baud_div[11:8] <= wdata[11:8];
            end
        end
    end

    // Oversampling tick at sixteen times the bit rate
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            baud_count <= '0;
            tick16 <= 1'b0;
            ext_clk_q <= 1'b0;
        end else begin
            ext_clk_q <= external_transfer_clock;
            tick16 <= baud_count == '0;
            baud_count <= (baud_count == '0) ? baud_div :
                baud_count - 12'h1;
        end
    end

    // Transmit buffer and flags; a write wins over a same-cycle load
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_buf <= '0;
            tx_full <= 1'b0;
            tx_done <= 1'b0;
            tx_live <= 1'b0;
        end else begin
            tx_live <= next_tx_live;
            if (wr_data) begin
                tx_buf <= {ctrl_b[B_TX_NINTH], wdata[7:0]};
                tx_full <= 1'b1;
            end else if (tx_load) begin
                tx_full <= 1'b0;
            end
            if (tx_last_stop && !tx_load) begin
                tx_done <= 1'b1;
            end else if (tx_done_irq_ack ||
                (wr_csa && wdata[A_TX_DONE])) begin
                tx_done <= 1'b0;
            end
        end
    end

    // Transmit sequencer; line idles high between frames
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_state <= TX_IDLE;
            tx_phase <= '0;
            tx_bits <= '0;
            tx_shreg <= '0;
            tx_parity <= 1'b0;
            tx_stops <= 1'b0;
            tx_line <= 1'b1;
        end else begin
            if (tick16) begin
                tx_phase <= tx_phase + 4'h1;
            end
            if (tx_load) begin
                tx_state <= TX_START;
                tx_shreg <= load_data;
                tx_parity <= ^load_data ^ parity_odd_select;
                tx_line <= 1'b0;
            end else if (tx_tick) begin
                case (tx_state)
                    TX_IDLE: begin
                        tx_line <= 1'b1;
                    end
                    TX_START: begin
                        tx_line <= tx_shreg[0];
                        tx_shreg <= tx_shreg >> 1;
                        tx_bits <= 4'h1;
                        tx_state <= TX_DATA;
                    end
                    TX_DATA: begin
                        if (tx_bits == data_bits) begin
                            tx_stops <= 1'b0;
                            tx_line <= parity_enable_bit ? tx_parity :
                                1'b1;
                            tx_state <= parity_enable_bit ? TX_PARITY :
                                TX_STOP;
                        end else begin
                            tx_line <= tx_shreg[0];
                            tx_shreg <= tx_shreg >> 1;
                            tx_bits <= tx_bits + 4'h1;
                        end
                    end
                    TX_PARITY: begin
                        tx_line <= 1'b1;
                        tx_state <= TX_STOP;
                    end
                    TX_STOP: begin
                        // Second stop bit only when selected
                        if (tx_stops == stop_bits_select) begin
                            tx_state <= TX_IDLE;
                        end else begin
                            tx_stops <= 1'b1;
                        end
                    end
                    default: begin
                        tx_state <= TX_IDLE;
                    end
                endcase
            end
        end
    end

    // Receive buffer: two entries, flushed while the receiver is off
    always_ff @(posedge aclk) begin
        if (!aresetn || !receiver_on) begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            rx_count <= '0;
            overrun_pending <= 1'b0;
            fifo_mem[0] <= '0;
            fifo_mem[1] <= '0;
        end else begin
            if (push) begin
                fifo_mem[wr_ptr] <= {link.frame_data[8], link.frame_fe,
                    overrun_pending, link.frame_pe,
                    link.frame_data[7:0]};
                wr_ptr <= !wr_ptr;
            end
            // Overrun tags the next frame that does get stored
            if (lost) begin
                overrun_pending <= 1'b1;
            end else if (push) begin
                overrun_pending <= 1'b0;
            end
            if (pop) begin
                rd_ptr <= !rd_ptr;
            end
            rx_count <= rx_count + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule : uart_core
`default_nettype wire

/* design/uart_pkg.sv */
// Constants, register map and state types of the serial port block
package uart_pkg;
    // Bus geometry
    localparam int AXI_ADDR_W = 5;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Register byte offsets
    localparam logic [4:0] OFS_DATA = 5'h00;
    localparam logic [4:0] OFS_CSA = 5'h04;
    localparam logic [4:0] OFS_CSB = 5'h08;
    localparam logic [4:0] OFS_CSC = 5'h0c;
    localparam logic [4:0] OFS_BAUD = 5'h10;
    // ctrl_status_a fields
    localparam int A_RX_COMPLETE = 7;
    localparam int A_TX_DONE = 6;
    localparam int A_TX_EMPTY = 5;
    localparam int A_FRAME_ERR = 4;
    localparam int A_OVERRUN = 3;
    localparam int A_PARITY_ERR = 2;
    // ctrl_status_b fields
    localparam int B_TXDONE_IE = 6;
    localparam int B_EMPTY_IE = 5;
    localparam int B_RX_ON = 4;
    localparam int B_TX_ON = 3;
    localparam int B_SIZE2 = 2;
    localparam int B_RX_NINTH = 1;
    localparam int B_TX_NINTH = 0;
    localparam logic [7:0] B_WRITE_MASK = 8'h7d;
    // ctrl_status_c fields
    localparam int C_SYNC = 6;
    localparam int C_PAR_EN = 5;
    localparam int C_PAR_ODD = 4;
    localparam int C_STOP2 = 3;
    localparam int C_SIZE_HI = 2;
    localparam int C_SIZE_LO = 1;
    // Reset values: 8 data bits, no parity, one stop
    localparam logic [7:0] RESET_CSB = 8'h00;
    localparam logic [7:0] RESET_CSC = 8'h06;
    localparam logic [11:0] RESET_BAUD = 12'h067;
    // Character size and frame timing
    localparam logic [2:0] SIZE_NINE = 3'h7;
    localparam logic [3:0] NINE_BITS = 4'h9;
    localparam logic [3:0] MIN_BITS = 4'h5;
    localparam logic [3:0] PHASE_HALF = 4'h7;
    localparam logic [3:0] PHASE_LAST = 4'hf;
    localparam int FIFO_DEPTH = 2;
    localparam int ENTRY_W = 12;
    // Transmit and receive sequencer states
    typedef enum logic [4:0] {
        TX_IDLE = 5'b00001,
        TX_START = 5'b00010,
        TX_DATA = 5'b00100,
        TX_PARITY = 5'b01000,
        TX_STOP = 5'b10000
    } tx_state_t;
    typedef enum logic [4:0] {
        RX_IDLE = 5'b00001,
        RX_START = 5'b00010,
        RX_DATA = 5'b00100,
        RX_PARITY = 5'b01000,
        RX_STOP = 5'b10000
    } rx_state_t;
endpackage : uart_pkg

/* design/rx_link_if.sv */
// Link between the register side and the receive shifter
`timescale 1ns/1ns
`default_nettype none
interface rx_link_if;
    logic enable;
    logic sync_mode;
    logic tick16;
    logic ext_rise;
    logic serial_in;
    logic parity_en;
    logic parity_odd;
    logic [3:0] data_bits;
    logic frame_valid;
    logic frame_fe;
    logic frame_pe;
    logic [8:0] frame_data;
    modport main (output enable, sync_mode, tick16, ext_rise, serial_in,
        parity_en, parity_odd, data_bits,
        input frame_valid, frame_fe, frame_pe, frame_data);
    modport engine (input enable, sync_mode, tick16, ext_rise, serial_in,
        parity_en, parity_odd, data_bits,
        output frame_valid, frame_fe, frame_pe, frame_data);
endinterface : rx_link_if
`default_nettype wire

/* design/rx_shifter.sv */
// Receive shifter: start detection, bit sampling, frame hand-off
`timescale 1ns/1ns
`default_nettype none
module rx_shifter (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Link to register side
    rx_link_if.engine link
);
    import uart_pkg::*;

    rx_state_t state;
    logic [3:0] phase;
    logic [3:0] bit_count;
    logic [8:0] shreg;
    logic parity_acc;
    logic parity_bad;

    // Bit sample point: external edge or centre of oversampled bit
    wire sample = link.sync_mode ? link.ext_rise :
        (link.tick16 && phase == PHASE_LAST);
    wire half_point = link.tick16 && phase == PHASE_HALF;
    wire [3:0] align = NINE_BITS - link.data_bits;
    wire parity_expect = parity_acc ^ link.parity_odd;

    // Disabled receiver drops any frame in progress
    always_ff @(posedge aclk) begin
        if (!aresetn || !link.enable) begin
            state <= RX_IDLE;
            phase <= '0;
            bit_count <= '0;
            shreg <= '0;
            parity_acc <= 1'b0;
            parity_bad <= 1'b0;
            link.frame_valid <= 1'b0;
            link.frame_fe <= 1'b0;
            link.frame_pe <= 1'b0;
            link.frame_data <= '0;
        end else begin
            link.frame_valid <= 1'b0;
            if (link.tick16) begin
                phase <= phase + 4'h1;
            end
            case (state)
                RX_IDLE: begin
                    bit_count <= '0;
                    parity_acc <= 1'b0;
                    parity_bad <= 1'b0;
                    if (!link.serial_in && link.sync_mode) begin
                        if (link.ext_rise) begin
                            state <= RX_DATA;
                        end
                    end else if (!link.serial_in) begin
                        state <= RX_START;
                        phase <= '0;
                    end
                end
                RX_START: begin
                    // Mid-bit recheck rejects glitches; phase resyncs here
                    if (half_point) begin
                        phase <= '0;
                        state <= link.serial_in ? RX_IDLE : RX_DATA;
                    end
                end
                RX_DATA: begin
                    if (sample) begin
                        shreg <= {link.serial_in, shreg[8:1]};
                        parity_acc <= parity_acc ^ link.serial_in;
                        bit_count <= bit_count + 4'h1;
                        if (bit_count == link.data_bits - 4'h1) begin
                            state <= link.parity_en ? RX_PARITY : RX_STOP;
                        end
                    end
                end
                RX_PARITY: begin
                    if (sample) begin
                        parity_bad <= parity_expect != link.serial_in;
                        state <= RX_STOP;
                    end
                end
                RX_STOP: begin
                    // Only the first stop bit is looked at
                    if (sample) begin
                        link.frame_valid <= 1'b1;
                        link.frame_data <= shreg >> align;
                        link.frame_fe <= !link.serial_in;
                        link.frame_pe <= parity_bad && link.parity_en;
                        state <= RX_IDLE;
                    end
                end
                default: begin
                    state <= RX_IDLE;
                end
            endcase
        end
    end
endmodule : rx_shifter
`default_nettype wire

/* verification/uart_core_chk.sv */
// Port-level assertions for the serial port block
`timescale 1ns/1ns
`default_nettype none
module uart_core_chk (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Bus handshakes
    input wire logic awvalid,
    input wire logic wvalid,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic rvalid,
    input wire logic rready,
    // Pins and requests
    input wire logic serial_out_pin,
    input wire logic serial_out_oe,
    input wire logic global_irq_enable,
    input wire logic tx_done_irq_ack,
    input wire logic buffer_empty_irq,
    input wire logic tx_done_irq
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Answers come one cycle after the take, and retire on their ready
    a_write_answer: assert property (awvalid && wvalid && !bvalid |=> bvalid)
        else $error("write answer missing");
    a_read_answer: assert property (arvalid && arready |=> rvalid)
        else $error("read answer missing");
    a_write_retire: assert property (bvalid && bready |=> !bvalid)
        else $error("write answer kept");
    a_read_retire: assert property (rvalid && rready |=> !rvalid)
        else $error("read answer kept");
    // A released line must sit at the idle level
    a_idle_high: assert property (!serial_out_oe |-> serial_out_pin)
        else $error("released line not high");
    // Requests only pass with the global enable
    a_empty_gate: assert property (buffer_empty_irq |-> global_irq_enable)
        else $error("empty request ungated");
    a_done_gate: assert property (tx_done_irq |-> global_irq_enable)
        else $error("done request ungated");
    a_ack_clears: assert property (tx_done_irq && tx_done_irq_ack
        |=> !tx_done_irq)
        else $error("service left done set");
    c_done_irq: cover property ($rose(tx_done_irq));
    c_empty_irq: cover property ($rose(buffer_empty_irq));
    c_oe_drop: cover property ($fell(serial_out_oe));
endmodule : uart_core_chk
bind uart_core uart_core_chk uart_core_chk_i (.*);
`default_nettype wire

/* verification/uart_remote.sv */
// Remote serial transceiver facing the block's data lines
`timescale 1ns/1ns
`default_nettype none
module uart_remote (
    // Clock
    input wire logic aclk,
    // Lines
    input wire logic serial_out_pin,
    input wire logic serial_out_oe,
    output logic serial_in_pin
);
    int nbits = 8;
    int frames = 0;
    logic par = 1'b0;
    logic [9:0] got;
    // Released line floats to its pull-up level
    wire line = serial_out_oe ? serial_out_pin : 1'b1;
    initial serial_in_pin = 1'b1;
    // One bit lasts 16 ticks at divisor zero
    task automatic bit_out(input logic b);
        serial_in_pin <= b;
        repeat (16) @(posedge aclk);
    endtask : bit_out
    // Start low, data LSB first, parity, one high stop
    task automatic send(input logic [8:0] d, input logic p);
        bit_out(1'b0);
        for (int i = 0; i < nbits; i++) bit_out(d[i]);
        if (par) bit_out(p);
        bit_out(1'b1);
    endtask : send
    // Capture the block's frames mid-bit
    always begin
        @(negedge line);
        repeat (8) @(posedge aclk);
        for (int i = 0; i <= nbits + par; i++) begin
            repeat (16) @(posedge aclk);
            got[i] = line;
        end
        frames++;
    end
endmodule : uart_remote
`default_nettype wire

/* verification/test_uart_core.sv */
// Self-checking bench for the serial port block
`timescale 1ns/1ns
`default_nettype none
module test_uart_core;
    import uart_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic arvalid = 1'b0;
    logic bready = 1'b1;
    logic rready = 1'b1;
    logic global_irq_enable = 1'b1;
    logic tx_done_irq_ack = 1'b0;
    logic external_transfer_clock = 1'b0;
    logic [3:0] wstrb = 4'hf;
    logic [4:0] awaddr = 5'h00;
    logic [4:0] araddr = 5'h00;
    logic [31:0] wdata = 32'h0;
    logic awready, wready, bvalid, arready, rvalid, hit;
    logic serial_out_pin, serial_out_oe, serial_in_pin, serial_in_owned;
    logic buffer_empty_irq, tx_done_irq;
    logic [1:0] bresp, rresp, rsq;
    logic [31:0] rdata, rdq, v;
    int failures = 0;
    int checks = 0;
    logic [3:0] xdiv = 4'h0;
    logic xsync = 1'b0;
    uart_core uart_core_i (.*);
    uart_remote uart_remote_i (.*);
    always #2 aclk = ~aclk;
    // Transfer clock: one rising edge every sixteen cycles once enabled
    always @(posedge aclk) begin
        xdiv <= xdiv + 4'h1;
        external_transfer_clock <= xsync && xdiv[3];
    end
    task automatic close_out;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : close_out
    task automatic chk(input string s, input logic [31:0] e, g);
        checks++;
        if (g !== e) begin
            failures++;
            $display("wrong value %s expected %h seen %h", s, e, g);
        end
    endtask : chk
    // Look before the edge, so the handshake edge is never raced
    task automatic await(input int k);
        int n;
        n = 0;
        do begin
            @(negedge aclk);
            n++;
            rdq = rdata;
            rsq = k == 1 ? bresp : rresp;
            hit = k == 0 ? awready && wready : k == 1 ? bvalid
                : k == 2 ? arready : rvalid;
        end while (hit !== 1'b1 && n < 500);
        if (hit !== 1'b1) begin
            failures++;
            close_out();
        end
        @(posedge aclk);
    endtask : await
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        await(0);
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        await(1);
    endtask : wr
    task automatic rd(input logic [4:0] a, output logic [31:0] d);
        araddr <= a;
        arvalid <= 1'b1;
        await(2);
        arvalid <= 1'b0;
        await(3);
        d = rdq;
    endtask : rd
    // Bounded poll of one status bit
    task automatic poll(input logic [4:0] a, input int b);
        for (int n = 0; n < 600; n++) begin
            rd(a, v);
            if (v[b] === 1'b1) return;
        end
        failures++;
        close_out();
    endtask : poll
    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        wr(OFS_BAUD, 8'h00);
        wr(OFS_CSB, 8'h18);
        chk("owned", 1, serial_in_owned);
        rd(OFS_CSA, v);
        chk("empty", 1, v[A_TX_EMPTY]);
        // Second byte waits in the buffer behind the first
        wr(OFS_DATA, 8'ha5);
        poll(OFS_CSA, A_TX_EMPTY);
        wr(OFS_DATA, 8'h3c);
        rd(OFS_CSA, v);
        chk("full", 0, v[A_TX_EMPTY]);
        chk("early done", 0, v[A_TX_DONE]);
        poll(OFS_CSA, A_TX_DONE);
        chk("frames", 2, uart_remote_i.frames);
        chk("tx byte", 8'h3c, uart_remote_i.got[7:0]);
        wr(OFS_CSB, 8'h78);
        chk("empty irq", 1, buffer_empty_irq);
        chk("done irq", 1, tx_done_irq);
        global_irq_enable <= 1'b0;
        @(negedge aclk);
        chk("gated", 0, buffer_empty_irq);
        @(posedge aclk);
        global_irq_enable <= 1'b1;
        tx_done_irq_ack <= 1'b1;
        @(posedge aclk);
        tx_done_irq_ack <= 1'b0;
        rd(OFS_CSA, v);
        chk("serviced", 0, v[A_TX_DONE]);
        // Even, then odd parity over three ones
        uart_remote_i.par = 1'b1;
        for (int o = 0; o < 2; o++) begin
            wr(OFS_CSC, o ? 8'h36 : 8'h26);
            wr(OFS_DATA, 8'h07);
            poll(OFS_CSA, A_TX_DONE);
            chk("parity", 1 ^ o, uart_remote_i.got[8]);
            wr(OFS_CSA, 8'h40);
            rd(OFS_CSA, v);
            chk("w1c", 0, v[A_TX_DONE]);
        end
        // Disable while the byte still waits in the buffer: pin kept until its frame ends
        uart_remote_i.par = 1'b0;
        wr(OFS_CSC, 8'h06);
        wr(OFS_DATA, 8'h81);
        wr(OFS_CSB, 8'h10);
        chk("oe hold", 1, serial_out_oe);
        poll(OFS_CSA, A_TX_DONE);
        chk("last byte", 8'h81, uart_remote_i.got[7:0]);
        chk("oe off", 0, serial_out_oe);
        // Six-bit character reads with zero upper bits
        wr(OFS_CSC, 8'h02);
        uart_remote_i.nbits = 6;
        uart_remote_i.send(9'h0ff, 1'b0);
        poll(OFS_CSA, A_RX_COMPLETE);
        rd(OFS_DATA, v);
        chk("masked", 8'h3f, v);
        // Nine bits, even parity; first frame carries a bad parity bit
        wr(OFS_CSB, 8'h14);
        wr(OFS_CSC, 8'h26);
        uart_remote_i.nbits = 9;
        uart_remote_i.par = 1'b1;
        uart_remote_i.send(9'h1a5, 1'b0);
        uart_remote_i.send(9'h05a, 1'b0);
        for (int k = 0; k < 2; k++) begin
            rd(OFS_CSA, v);
            chk("perr", k == 0, v[A_PARITY_ERR]);
            rd(OFS_CSB, v);
            chk("ninth", k == 0, v[B_RX_NINTH]);
            rd(OFS_DATA, v);
            chk("low byte", k ? 8'h5a : 8'ha5, v);
        end
        uart_remote_i.send(9'h011, 1'b0);
        poll(OFS_CSA, A_RX_COMPLETE);
        // Receiver off; ninth transmit bit set before the data write
        wr(OFS_CSB, 8'h0d);
        rd(OFS_CSA, v);
        chk("flushed", 0, v[A_RX_COMPLETE]);
        chk("released", 0, serial_in_owned);
        // Nine bits paced by the transfer clock, no parity
        xsync <= 1'b1;
        uart_remote_i.par = 1'b0;
        wr(OFS_CSC, 8'h46);
        wr(OFS_CSA, 8'h40);
        wr(OFS_DATA, 8'h96);
        poll(OFS_CSA, A_TX_DONE);
        chk("sync frame", 9'h196, uart_remote_i.got[8:0]);
        rd(5'h14, v);
        chk("unmapped", RESP_SLVERR, rsq);
        wr(5'h14, 8'h00);
        chk("unmapped wr", RESP_SLVERR, rsq);
        close_out();
    end
endmodule : test_uart_core
`default_nettype wire
